// >>> verif/adc_serial_monitor.sv
// timing checks on the converter top ports, bound into every instance
// assumes one clock domain on core_clk and the async low reset resetn
`timescale 1ns/1ps
module adc_monitor (
    input wire core_clk,
    input wire resetn,
    input wire select_n,
    input wire sclk,
    input wire serial_in,
    input wire serial_out,
    input wire serial_out_en,
    input wire low_power,
    input wire conv_busy,
    input wire single_or_diff_sel,
    input wire polarity_sel,
    input wire frame_abort,
    input wire result_valid,
    input wire result_ready,
    input wire [9:0] result_data
);
    // all checks share the core clock and its reset
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    idle_release_a: assert property ($past(select_n) |-> !serial_out_en && low_power)
        else $error("output driven while deselected");
    settle_zero_a: assert property ($rose(serial_out_en) |-> !serial_out)
        else $error("first driven bit not zero");
    out_steady_a: assert property (sclk && $past(sclk) |-> $stable(serial_out))
        else $error("output moved while serial clock high");
    addr_latch_a: assert property ($changed({single_or_diff_sel, polarity_sel}) |-> $past(sclk) && !$past(sclk, 2))
        else $error("address latched off a rising serial clock");
    addr_freeze_a: assert property (serial_out_en && $past(serial_out_en) |-> $stable({single_or_diff_sel, polarity_sel}))
        else $error("address changed during conversion");
    busy_start_a: assert property ($rose(conv_busy) |-> $past(serial_in) && $past(sclk) && !$past(select_n))
        else $error("conversion started without start bit");
    drive_start_a: assert property ($rose(serial_out_en) |-> conv_busy && !low_power)
        else $error("output driven outside a conversion");
    abort_pulse_a: assert property (frame_abort |-> $past(select_n) ##1 !frame_abort)
        else $error("abort pulse without deselect");
    tail_low_a: assert property (!conv_busy && $past(!conv_busy) && serial_out_en |-> !serial_out)
        else $error("tail not held low");
    queue_hold_a: assert property (result_valid && !result_ready |=> result_valid && $stable(result_data))
        else $error("queue output dropped while stalled");
endmodule

bind serial_adc_mux_interface adc_monitor i_adc_monitor (.*);

// >>> verif/ctrl_model.sv
// serial master model: select, serial clock and data in whole frames
// assumes core_clk at 100 MHz; each serial clock phase spans 4 core cycles
`timescale 1ns/1ps
module ctrl_model (
    input wire core_clk,
    input wire serial_out,
    input wire conv_busy,
    output logic select_n,
    output logic sclk,
    output logic serial_in
);
    // clock stands low between frames so release never looks like a rise
    initial begin
        select_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
    end
    // lead zeros, start, mode, polarity, then toggling filler the device must ignore
    task automatic frame(input logic mode, pol, input int lead, ncyc, output logic [19:0] cap, output logic busy);
        int i;
        logic [2:0] hdr;
        hdr = {1'b1, mode, pol};
        cap = 20'h0;
        busy = 1'b0;
        @(posedge core_clk) #1 select_n = 1'b0;
        for (i = 0; i < lead + ncyc; i++) begin
            serial_in = (i < lead) ? 1'b0 : (i - lead < 3) ? hdr[2 - i + lead] : i[0];
            repeat (4) @(posedge core_clk);
            #1 sclk = 1'b1;
            if (i >= lead) cap[i - lead] = serial_out;
            busy |= conv_busy;
            repeat (4) @(posedge core_clk);
            #1 sclk = 1'b0;
        end
        @(posedge core_clk) #1 select_n = 1'b1;
        serial_in = ~serial_in; // released line shows no stale value
    endtask
endmodule

// >>> verif/tb_top.sv
// self-checking bench: frames in all modes, an abort, queue fill and drain
// assumes the controller model and the bound monitor are compiled first
`timescale 1ns/1ps
module tb_top;
    logic core_clk, resetn, result_ready;
    logic [7:0] ch0_level, ch1_level;
    wire select_n, sclk, serial_in, serial_out, serial_out_en, low_power, conv_busy;
    wire single_or_diff_sel, polarity_sel, frame_abort, result_valid;
    wire [9:0] result_data;
    logic [19:0] cap;
    logic busy;
    int miscompares = 0;
    int tests_run = 0;

    serial_adc_mux_interface i_serial_adc_mux_interface (.core_clk(core_clk), .resetn(resetn),
        .select_n(select_n), .sclk(sclk), .serial_in(serial_in), .ch0_level(ch0_level),
        .ch1_level(ch1_level), .serial_out(serial_out), .serial_out_en(serial_out_en),
        .low_power(low_power), .conv_busy(conv_busy), .single_or_diff_sel(single_or_diff_sel),
        .polarity_sel(polarity_sel), .frame_abort(frame_abort), .result_valid(result_valid),
        .result_ready(result_ready), .result_data(result_data));
    ctrl_model i_ctrl_model (.core_clk(core_clk), .serial_out(serial_out), .conv_busy(conv_busy),
        .select_n(select_n), .sclk(sclk), .serial_in(serial_in));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [19:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude;
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // clipped difference, positive side picked by polarity
    function automatic logic [7:0] conv(input logic pol, input logic [7:0] a0, a1);
        logic [7:0] p, n;
        p = pol ? a1 : a0;
        n = pol ? a0 : a1;
        return (p > n) ? p - n : 8'h00;
    endfunction

    // full frame; bits 2..0 are sampled before the output is driven
    task automatic do_frame(input logic mode, pol, input int lead);
        logic [7:0] c;
        logic [19:0] e;
        int k;
        c = conv(pol, ch0_level, ch1_level);
        e = 20'h0;
        for (k = 0; k < 8; k++) e[4 + k] = c[7 - k];
        for (k = 1; k < 8; k++) e[11 + k] = c[k];
        i_ctrl_model.frame(mode, pol, lead, 20, cap, busy);
        check(cap & 20'hFFFF8, e);
        check({busy, single_or_diff_sel, polarity_sel}, {1'b1, mode, pol});
        repeat (2) @(posedge core_clk);
        #1 check({serial_out_en, low_power}, 2'b01);
    endtask

    task automatic pop(input logic [9:0] exp);
        check({result_valid, result_data}, {1'b1, exp});
        @(posedge core_clk) #1 result_ready = 1'b1;
        @(posedge core_clk) #1 result_ready = 1'b0;
    endtask

    // every mode and polarity, 0..3 leading zeros, a negative difference in both polarity-one frames
    task automatic t_modes;
        int m;
        ch0_level = 8'hA5;
        ch1_level = 8'h3C;
        for (m = 0; m < 4; m++) begin
            do_frame(m[1], m[0], m);
            pop({m[1], m[0], conv(m[0], ch0_level, ch1_level)});
        end
    endtask

    // deselect in mid conversion: pulse, release, nothing queued
    task automatic t_abort;
        int n;
        logic seen;
        seen = 1'b0;
        i_ctrl_model.frame(1'b0, 1'b1, 0, 8, cap, busy);
        for (n = 0; n < 4; n++) begin
            @(posedge core_clk) #1 seen |= frame_abort;
        end
        check({seen, result_valid, low_power}, 3'b101);
    endtask

    // positive input moved after acquisition must not reach the result
    task automatic t_hold;
        ch0_level = 8'h80;
        ch1_level = 8'h10;
        fork
            do_frame(1'b0, 1'b0, 0);
            begin
                repeat (40) @(posedge core_clk);
                #1 ch0_level = 8'hF0;
            end
        join
        pop({2'b00, 8'h70});
    endtask

    // consumer stalls: nine results fit, the tenth start is held off
    task automatic t_fill;
        int j;
        ch1_level = 8'h02;
        for (j = 0; j < 9; j++) begin
            ch0_level = 8'h05 + 8'(j * 16);
            do_frame(1'b1, 1'b0, 0);
        end
        i_ctrl_model.frame(1'b1, 1'b0, 0, 20, cap, busy);
        check(busy, 1'b0);
        for (j = 0; j < 9; j++) pop({2'b10, 8'h03 + 8'(j * 16)});
    endtask

    initial begin
        resetn = 1'b0;
        result_ready = 1'b0;
        ch0_level = 8'h00;
        ch1_level = 8'h00;
        repeat (6) @(posedge core_clk);
        #1 resetn = 1'b1;
        repeat (3) @(posedge core_clk);
        #1 t_modes;
        t_abort;
        do_frame(1'b0, 1'b0, 1);
        pop({2'b00, 8'h69});
        t_hold;
        t_fill;
        conclude;
    end

    // about 2800 cycles expected; cut off well beyond
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        conclude;
    end
endmodule

// >>> verilog/adc_serial_defines.vh
// constants for the serial converter front end and its result queue
// assumes inclusion by bare name from the design files only
`ifndef ADC_SERIAL_DEFINES_VH
`define ADC_SERIAL_DEFINES_VH

// width of a conversion result
`define RESULT_BITS 8
// index of the first trial bit (msb)
`define RESULT_MSB 3'h7
// mux address bits that follow the start bit
`define ADDR_BITS 2
// address bit positions counted from the first bit after the start bit
`define ADDR_MODE_POS 1'h0
`define ADDR_POL_POS 1'h1
// mode and polarity encodings
`define MODE_SINGLE 1'h1
`define MODE_DIFF 1'h0
`define POL_CH0_POS 1'h0
`define POL_CH1_POS 1'h1
// bits sent lsb first after the msb-first pass (bit 0 is not repeated)
`define LSB_PASS_BITS 3'h7
// queue entry: {mode, polarity, result}
`define ENTRY_BITS 10
`define QUEUE_DEPTH 8
`define QUEUE_ADDR_BITS 3

`endif

// >>> verilog/serial_adc_mux_interface.v
// serial control side of an 8-bit successive approximation converter
// with a two-input multiplexer, plus the queue that holds its results.
// assumes select_n, sclk and serial_in are synchronous to core_clk and
// that sclk runs far slower than core_clk; analog levels arrive as codes.
// a stalled consumer fills the queue and then holds off new start bits.
`timescale 1ns/1ps
`include "adc_serial_defines.vh"

// result queue with a registered output stage
module result_queue #(
    parameter WIDTH = `ENTRY_BITS,
    parameter DEPTH = `QUEUE_DEPTH,
    parameter ADDR_W = `QUEUE_ADDR_BITS
) (
    input wire core_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    // storage and its pointers
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [ADDR_W-1:0] wr_ptr;
    reg [ADDR_W-1:0] rd_ptr;
    // fill level, one bit wider than the pointers
    reg [ADDR_W:0] count;

    // handshake strobes
    wire push;
    wire pop;

    // full and empty come from the same counter, so they never disagree
    assign in_ready = (count != DEPTH[ADDR_W:0]);
    assign push = in_valid & in_ready;
    assign pop = (count != {(ADDR_W+1){1'b0}}) & (~out_valid | out_ready);

    // storage has no reset; pointers, the counter and the output stage get one
    always @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers, fill level and output stage
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {ADDR_W{1'b0}};
            rd_ptr <= {ADDR_W{1'b0}};
            count <= {(ADDR_W+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            // output stage refills when empty or being taken
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            // push and pop together leave the fill level alone
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

module serial_adc_mux_interface (
    input wire core_clk,
    input wire resetn,
    input wire select_n,
    input wire sclk,
    input wire serial_in,
    input wire [`RESULT_BITS-1:0] ch0_level,
    input wire [`RESULT_BITS-1:0] ch1_level,
    output reg serial_out,
    output reg serial_out_en,
    output reg low_power,
    output reg conv_busy,
    output reg single_or_diff_sel,
    output reg polarity_sel,
    output reg frame_abort,
    output wire result_valid,
    input wire result_ready,
    output wire [`ENTRY_BITS-1:0] result_data
);
    // one-hot states of the conversion sequence
    localparam [5:0] ST_WAIT = 6'h01;
    localparam [5:0] ST_ADDR = 6'h02;
    localparam [5:0] ST_SETTLE = 6'h04;
    localparam [5:0] ST_CONVERT = 6'h08;
    localparam [5:0] ST_LSB = 6'h10;
    localparam [5:0] ST_TAIL = 6'h20;

    // reset synchroniser pair
    reg rst_meta;
    reg rst_sync;

    // serial clock history and sequencer state
    reg sclk_q;
    reg [5:0] state;
    reg addr_cnt;
    reg [2:0] bit_idx;
    reg [2:0] lsb_cnt;

    // approximation registers
    reg [`RESULT_BITS-1:0] pos_held;
    reg [`RESULT_BITS-1:0] sar;
    reg [`RESULT_BITS-1:0] shifter;

    // hand-off to the result queue
    reg q_valid;
    reg [`ENTRY_BITS-1:0] q_data;
    wire q_ready;

    // edge strobes and comparator trial
    wire sclk_rise;
    wire sclk_fall;
    wire [`RESULT_BITS-1:0] neg_now;
    reg [`RESULT_BITS-1:0] trial;
    reg [`RESULT_BITS:0] neg_plus_trial;
    reg decision;
    reg [`RESULT_BITS-1:0] next_sar;

    // picks one of the two channel codes
    function [`RESULT_BITS-1:0] pick_channel;
        input take_ch1;
        input [`RESULT_BITS-1:0] a0;
        input [`RESULT_BITS-1:0] a1;
        begin
            pick_channel = take_ch1 ? a1 : a0;
        end
    endfunction

    // reset release through two flops; assertion stays asynchronous
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // serial clock is a sampled input, not a clock domain
    always @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= sclk;
        end
    end

    // each strobe lasts one core clock, so sclk phases must span at least one
    assign sclk_rise = sclk & ~sclk_q;
    assign sclk_fall = ~sclk & sclk_q;

    // negative input is read fresh for every decision
    assign neg_now = pick_channel(polarity_sel == `POL_CH0_POS, ch0_level, ch1_level);

    // one trial of the approximation: keep the bit if pos >= neg + trial
    always @* begin
        // trial sets the bit under test on top of the bits kept so far
        trial = sar | ({{(`RESULT_BITS-1){1'b0}}, 1'b1} << bit_idx);
        neg_plus_trial = {1'b0, neg_now} + {1'b0, trial};
        // a positive input below the negative one never keeps a bit
        decision = ({1'b0, pos_held} >= neg_plus_trial);
        next_sar = decision ? trial : sar;
    end

    // conversion sequencer, advanced by serial clock edges
    always @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            // released line, parked sequencer, default mux setting
            state <= ST_WAIT;
            addr_cnt <= 1'b0;
            bit_idx <= `RESULT_MSB;
            lsb_cnt <= 3'h0;
            pos_held <= {`RESULT_BITS{1'b0}};
            sar <= {`RESULT_BITS{1'b0}};
            shifter <= {`RESULT_BITS{1'b0}};
            serial_out <= 1'b0;
            serial_out_en <= 1'b0;
            low_power <= 1'b1;
            conv_busy <= 1'b0;
            single_or_diff_sel <= `MODE_SINGLE;
            polarity_sel <= `POL_CH0_POS;
            frame_abort <= 1'b0;
            q_valid <= 1'b0;
            q_data <= {`ENTRY_BITS{1'b0}};
        end else begin
            // one-cycle strobes drop unless set below
            frame_abort <= 1'b0;
            q_valid <= 1'b0;
            if (select_n) begin
                // deselect ends any frame and parks the logic
                state <= ST_WAIT;
                serial_out_en <= 1'b0;
                serial_out <= 1'b0;
                low_power <= 1'b1;
                conv_busy <= 1'b0;
                // the mux setting keeps its last latched value
                addr_cnt <= 1'b0;
                // a frame cut short by the controller is flagged once
                frame_abort <= ~state[0] & ~state[5];
            end else begin
                // selected: leave low power at once
                low_power <= 1'b0;
                // one branch per one-hot state
                case (state)
                    ST_WAIT: begin
                        // zeros before the start bit fall through; a full queue
                        // also holds off the start so no result is dropped
                        if (sclk_rise && serial_in && q_ready) begin
                            state <= ST_ADDR;
                            addr_cnt <= `ADDR_MODE_POS;
                            conv_busy <= 1'b1;
                        end
                    end

                    ST_ADDR: begin
                        // output still undriven, so a shared wire is safe here
                        if (sclk_rise) begin
                            // first rise after the start bit carries the mode
                            if (addr_cnt == `ADDR_MODE_POS) begin
                                single_or_diff_sel <= serial_in;
                                addr_cnt <= `ADDR_POL_POS;
                            end else begin
                                // second rise carries the polarity
                                polarity_sel <= serial_in;
                                state <= ST_SETTLE;
                            end
                        end
                    end

                    ST_SETTLE: begin
                        // half a clock after the polarity bit: acquire the positive
                        // input and drive the settling zero
                        if (sclk_fall) begin
                            pos_held <= pick_channel(polarity_sel == `POL_CH1_POS,
                                                     ch0_level, ch1_level);
                            serial_out_en <= 1'b1;
                            serial_out <= 1'b0;
                            // clear the approximation for this frame
                            sar <= {`RESULT_BITS{1'b0}};
                            bit_idx <= `RESULT_MSB;
                            state <= ST_CONVERT;
                        end
                    end

                    ST_CONVERT: begin
                        // serial_in is not looked at from here to deselect
                        if (sclk_fall) begin
                            // each decision goes out on the fall that records it
                            sar <= next_sar;
                            serial_out <= decision;
                            if (bit_idx == 3'h0) begin
                                // bit 0 just went out, start the lsb pass at bit 1
                                shifter <= next_sar >> 1;
                                lsb_cnt <= 3'h0;
                                q_valid <= 1'b1;
                                q_data <= {single_or_diff_sel, polarity_sel, next_sar};
                                state <= ST_LSB;
                            end else begin
                                bit_idx <= bit_idx - 1'b1;
                            end
                        end
                    end

                    ST_LSB: begin
                        // seven bits; bit 0 already went out in the msb pass
                        if (sclk_fall) begin
                            serial_out <= shifter[0];
                            shifter <= shifter >> 1;
                            lsb_cnt <= lsb_cnt + 1'b1;
                            if (lsb_cnt == `LSB_PASS_BITS - 3'h1) begin
                                state <= ST_TAIL;
                            end
                        end
                    end

                    ST_TAIL: begin
                        // frame done; line held low until the controller lets go
                        if (sclk_fall) begin
                            serial_out <= 1'b0;
                            conv_busy <= 1'b0;
                        end
                    end

                    // unused one-hot codes fall back to idle
                    default: begin
                        state <= ST_WAIT;
                    end
                endcase
            end
        end
    end

    // finished conversions wait here for the consumer
    result_queue #(
        .WIDTH(`ENTRY_BITS),
        .DEPTH(`QUEUE_DEPTH),
        .ADDR_W(`QUEUE_ADDR_BITS)
    ) u_queue (
        .core_clk(core_clk),
        .rst_n(rst_sync),
        .in_valid(q_valid),
        .in_ready(q_ready),
        .in_data(q_data),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(result_data)
    );
endmodule
